/* pott_cfg.svh */
// timing constants and setting defaults for the permissive trip scheme
`ifndef POTT_CFG_SVH
`define POTT_CFG_SVH

// clock rate in hertz and period in nanoseconds
`define CLK_HZ              10000000
`define CLK_PERIOD_NS       100
// timer width in bits
`define TIMER_W             24
// setting defaults, in microseconds
`define RX_QUAL_US          2000
`define REV_WINDOW_US       20000
`define REV_BLOCK_US        90000
`define ECHO_PULSE_US       10000
`define ECHO_HOLDOFF_US     250000
`define OPEN_QUAL_US        50000
`define TRIP_HOLD_US        10000
// cycles per microsecond
`define CYC_PER_US          (`CLK_HZ / 1000000)
// enable defaults
`define RETURN_EN_RST       1'b0
// apb register byte offsets
`define OFF_CTRL            12'h000
`define OFF_RXQ             12'h004
`define OFF_WIN             12'h008
`define OFF_BLK             12'h00c
`define OFF_EPL             12'h010
`define OFF_EHO             12'h014
`define OFF_OPQ             12'h018
`define OFF_HOLD            12'h01c
`define OFF_STAT            12'h020
// control and status field positions
`define CTRL_RET_EN_BIT     0
`define STAT_TX_BIT         0
`define STAT_TRIP_BIT       1
`define STAT_RXQ_BIT        2
`define STAT_OPEN_BIT       3
`define STAT_ECHO_BIT       4
`define STAT_GBLK_BIT       5

`endif

/* pott_pkg.sv */
// types shared by the permissive trip scheme files
package pott_pkg;
    // apb request from the master
    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } apb_req_t;
    // echo sequencer states, one-hot
    typedef enum logic [2:0] {
        ECHO_IDLE  = 3'b001,
        ECHO_PULSE = 3'b010,
        ECHO_HOLD  = 3'b100
    } echo_state_t;
    // local field inputs
    typedef struct packed {
        logic zone2_pickup;
        logic ground_forward_indication;
        logic permissive_receive;
        logic line_end_open_detect;
    } field_in_t;
endpackage

/* pott_qualify.sv */
// pickup qualifier: output rises after input held high for a set time
`timescale 1ns/10ps
`include "pott_cfg.svh"

module pott_qualify #(
    parameter int W = `TIMER_W
) (
    input  wire logic         clk,
    input  wire logic         reset,
    input  wire logic         level,
    input  wire logic [W-1:0] delay,
    output logic              qualified,
    output logic              rise
);
    // =========================================================
    // continuous-high counter
    logic [W-1:0] cnt_q;      // cycles input has stayed high
    logic         qual_q;     // qualified level
    wire          done = (cnt_q >= delay);

    // any low cycle restarts the count, so glitches never qualify
    always_ff @(posedge clk) begin
        if (reset || !level) begin
            cnt_q  <= '0;
            qual_q <= 1'b0;
        end else begin
            if (!done)
                cnt_q <= cnt_q + 1'b1;
            qual_q <= done;
        end
    end

    assign qualified = qual_q;
    assign rise      = level && done && !qual_q;
endmodule

/* pott_scheme.sv */
// permissive over-reaching transfer trip logic with apb settings
//
// Operation
// - zone 2 pickup keys and compares
// - ground forward indication also keys scheme
// - echo on qualified receive at open end
// - one echo, then holdoff before next
// - echo pulse has fixed programmed length
// - receive accepted after continuous qualify delay
// - transient blocking only on ground path
// - ground permission: delay, window cut, block
// - open end valid after qualify delay
// - trip held at least hold time
//
// The address map and the APB interface to the registers were left to the implementer.
`timescale 1ns/10ps
`include "pott_cfg.svh"

module pott_scheme #(
    parameter int W = `TIMER_W,
    parameter int RX_QUAL_CYC   = `RX_QUAL_US * `CYC_PER_US,
    parameter int REV_WIN_CYC   = `REV_WINDOW_US * `CYC_PER_US,
    parameter int REV_BLK_CYC   = `REV_BLOCK_US * `CYC_PER_US,
    parameter int ECHO_PL_CYC   = `ECHO_PULSE_US * `CYC_PER_US,
    parameter int ECHO_HO_CYC   = `ECHO_HOLDOFF_US * `CYC_PER_US,
    parameter int OPEN_QUAL_CYC = `OPEN_QUAL_US * `CYC_PER_US,
    parameter int TRIP_HOLD_CYC = `TRIP_HOLD_US * `CYC_PER_US
) (
    input  wire logic              clk,
    input  wire logic              reset,
    input  wire pott_pkg::field_in_t field_in,
    input  wire pott_pkg::apb_req_t  apb_req,
    output logic [31:0]            prdata,
    output logic                   pready,
    output logic                   pslverr,
    output logic                   permissive_transmit,
    output logic                   scheme_trip_output
);
    // =========================================================
    // apb settings registers
    logic         ret_en_q;          // return_enable
    logic [W-1:0] rxq_q;             // receive_qualify_delay
    logic [W-1:0] win_q;             // reversal_window_time
    logic [W-1:0] blk_q;             // reversal_block_time
    logic [W-1:0] epl_q;             // return_pulse_length
    logic [W-1:0] eho_q;             // return_holdoff_time
    logic [W-1:0] opq_q;             // open_end_qualify_delay
    logic [W-1:0] hold_q;            // trip_hold_time
    logic [31:0]  prdata_q;
    logic         pready_q;
    logic         pslverr_q;

    // access phase takes effect on the edge where pready is high
    wire setup  = apb_req.psel && !apb_req.penable;
    wire access = apb_req.psel && apb_req.penable && pready_q;
    wire wr     = access && apb_req.pwrite;
    wire [11:0] a = apb_req.paddr;
    wire [W-1:0] wv = apb_req.pwdata[W-1:0];
    wire hit = (a == `OFF_CTRL) || (a == `OFF_RXQ) || (a == `OFF_WIN)
            || (a == `OFF_BLK) || (a == `OFF_EPL) || (a == `OFF_EHO)
            || (a == `OFF_OPQ) || (a == `OFF_HOLD) || (a == `OFF_STAT);
    wire stat_wr = (a == `OFF_STAT);

    // live status word
    logic [31:0] stat_w;
    logic [31:0] rd_w;

    // settings writes; unmapped or status writes change nothing
    always_ff @(posedge clk) begin
        if (reset) begin
            ret_en_q <= `RETURN_EN_RST;
            rxq_q    <= W'(RX_QUAL_CYC);
            win_q    <= W'(REV_WIN_CYC);
            blk_q    <= W'(REV_BLK_CYC);
            epl_q    <= W'(ECHO_PL_CYC);
            eho_q    <= W'(ECHO_HO_CYC);
            opq_q    <= W'(OPEN_QUAL_CYC);
            hold_q   <= W'(TRIP_HOLD_CYC);
        end else if (wr) begin
            case (a)
                `OFF_CTRL: ret_en_q <= apb_req.pwdata[`CTRL_RET_EN_BIT];
                `OFF_RXQ:  rxq_q    <= wv;
                `OFF_WIN:  win_q    <= wv;
                `OFF_BLK:  blk_q    <= wv;
                `OFF_EPL:  epl_q    <= wv;
                `OFF_EHO:  eho_q    <= wv;
                `OFF_OPQ:  opq_q    <= wv;
                `OFF_HOLD: hold_q   <= wv;
                default:   ret_en_q <= ret_en_q;
            endcase
        end
    end

    // read mux, zero for unmapped
    always_comb begin
        rd_w = 32'h0000_0000;
        case (a)
            `OFF_CTRL: rd_w[`CTRL_RET_EN_BIT] = ret_en_q;
            `OFF_RXQ:  rd_w[W-1:0] = rxq_q;
            `OFF_WIN:  rd_w[W-1:0] = win_q;
            `OFF_BLK:  rd_w[W-1:0] = blk_q;
            `OFF_EPL:  rd_w[W-1:0] = epl_q;
            `OFF_EHO:  rd_w[W-1:0] = eho_q;
            `OFF_OPQ:  rd_w[W-1:0] = opq_q;
            `OFF_HOLD: rd_w[W-1:0] = hold_q;
            `OFF_STAT: rd_w = stat_w;
            default:   rd_w = 32'h0000_0000;
        endcase
    end

    // one wait state: pready rises in the second access cycle
    always_ff @(posedge clk) begin
        if (reset) begin
            pready_q  <= 1'b0;
            prdata_q  <= 32'h0000_0000;
            pslverr_q <= 1'b0;
        end else if (apb_req.psel && apb_req.penable && !pready_q) begin
            pready_q  <= 1'b1;
            prdata_q  <= apb_req.pwrite ? 32'h0000_0000 : rd_w;
            pslverr_q <= !hit || (apb_req.pwrite && stat_wr);
        end else begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            if (setup)
                prdata_q <= 32'h0000_0000;
        end
    end

    // =========================================================
    // input qualification
    logic rx_ok;        // receive held for qualify delay
    logic rx_rise;
    logic open_ok;      // line end open validated

    pott_qualify #(.W(W)) u_rxq (
        .clk       (clk),
        .reset     (reset),
        .level     (field_in.permissive_receive),
        .delay     (rxq_q),
        .qualified (rx_ok),
        .rise      ()
    );

    pott_qualify #(.W(W)) u_opq (
        .clk       (clk),
        .reset     (reset),
        .level     (field_in.line_end_open_detect),
        .delay     (opq_q),
        .qualified (open_ok),
        .rise      ()
    );

    // raw receive edge starts the reversal window
    logic rx_prev_q;
    always_ff @(posedge clk) begin
        if (reset)
            rx_prev_q <= 1'b0;
        else
            rx_prev_q <= field_in.permissive_receive;
    end
    assign rx_rise = field_in.permissive_receive && !rx_prev_q;

    // =========================================================
    // ground path shaping: window then block
    logic [W-1:0] win_cnt_q;    // cycles since raw receive pickup
    logic         win_act_q;    // inside pass window
    logic [W-1:0] blk_cnt_q;    // block countdown
    wire          gnd_blocked = (blk_cnt_q != '0);

    // window from pickup, then block period
    always_ff @(posedge clk) begin
        if (reset) begin
            win_cnt_q <= '0;
            win_act_q <= 1'b0;
            blk_cnt_q <= '0;
        end else if (win_act_q) begin
            if (win_cnt_q + 1'b1 >= win_q) begin
                win_act_q <= 1'b0;
                blk_cnt_q <= blk_q;
            end
            win_cnt_q <= win_cnt_q + 1'b1;
        end else if (gnd_blocked) begin
            blk_cnt_q <= blk_cnt_q - 1'b1;
        end else if (rx_rise) begin
            // a fresh pickup only opens a window outside the block
            win_act_q <= 1'b1;
            win_cnt_q <= '0;
        end
    end

    // only ground path sees the window and block
    wire gnd_perm = rx_ok && win_act_q && !gnd_blocked;

    // =========================================================
    // echo sequencer
    pott_pkg::echo_state_t echo_q;
    pott_pkg::echo_state_t echo_d;
    logic [W-1:0] echo_cnt_q;
    wire echo_cnt_done = (echo_cnt_q + 1'b1 >= epl_q);
    wire hold_cnt_done = (echo_cnt_q + 1'b1 >= eho_q);
    // echo request at validated open end
    wire echo_req = ret_en_q && rx_ok && open_ok;

    // one-shot: idle to pulse to holdoff
    always_comb begin
        case (echo_q)
            pott_pkg::ECHO_IDLE:
                echo_d = echo_req ? pott_pkg::ECHO_PULSE
                                  : pott_pkg::ECHO_IDLE;
            pott_pkg::ECHO_PULSE:
                echo_d = echo_cnt_done ? pott_pkg::ECHO_HOLD
                                       : pott_pkg::ECHO_PULSE;
            pott_pkg::ECHO_HOLD:
                echo_d = hold_cnt_done ? pott_pkg::ECHO_IDLE
                                       : pott_pkg::ECHO_HOLD;
            default:
                echo_d = pott_pkg::ECHO_IDLE;
        endcase
    end

    // pulse length counted, independent of receive
    always_ff @(posedge clk) begin
        if (reset) begin
            echo_q     <= pott_pkg::ECHO_IDLE;
            echo_cnt_q <= '0;
        end else begin
            echo_q     <= echo_d;
            echo_cnt_q <= (echo_d != echo_q) ? '0 : echo_cnt_q + 1'b1;
        end
    end

    // =========================================================
    // transmit and trip outputs
    logic         tx_q;
    logic         trip_q;
    logic [W-1:0] trip_cnt_q;   // cycles trip has been held since trip_cond dropped

    // trip terms: zone 2 or shaped ground path
    wire trip_cond = (rx_ok && field_in.zone2_pickup)
                  || (gnd_perm && field_in.ground_forward_indication);

    // keying from either forward source or echo
    wire tx_d = field_in.zone2_pickup
             || field_in.ground_forward_indication
             || (echo_d == pott_pkg::ECHO_PULSE);

    always_ff @(posedge clk) begin
        if (reset) begin
            tx_q       <= 1'b0;
            trip_q     <= 1'b0;
            trip_cnt_q <= '0;
        end else begin
            tx_q <= tx_d;
            if (trip_cond) begin
                trip_q     <= 1'b1;
                trip_cnt_q <= '0;
            end else if (trip_q && (trip_cnt_q + 1'b1 >= hold_q)) begin
                trip_q <= 1'b0;
            end else if (trip_q) begin
                trip_cnt_q <= trip_cnt_q + 1'b1;
            end
        end
    end

    always_comb begin
        stat_w = 32'h0000_0000;
        stat_w[`STAT_TX_BIT]   = tx_q;
        stat_w[`STAT_TRIP_BIT] = trip_q;
        stat_w[`STAT_RXQ_BIT]  = rx_ok;
        stat_w[`STAT_OPEN_BIT] = open_ok;
        stat_w[`STAT_ECHO_BIT] = (echo_q == pott_pkg::ECHO_PULSE);
        stat_w[`STAT_GBLK_BIT] = gnd_blocked;
    end

    assign prdata              = prdata_q;
    assign pready              = pready_q;
    assign pslverr             = pslverr_q;
    assign permissive_transmit = tx_q;
    assign scheme_trip_output  = trip_q;
endmodule

/* pott_scheme_asserts.sv */
// concurrent checks on the permissive trip scheme ports
`timescale 1ns/10ps
module pott_scheme_asserts #(
    parameter int RX_QUAL_CYC   = 4,
    parameter int ECHO_HO_CYC   = 20,
    parameter int TRIP_HOLD_CYC = 10
) (
    input wire logic                clk,
    input wire logic                reset,
    input wire pott_pkg::field_in_t field_in,
    input wire pott_pkg::apb_req_t  apb_req,
    input wire logic [31:0]         prdata,
    input wire logic                pready,
    input wire logic                pslverr,
    input wire logic                permissive_transmit,
    input wire logic                scheme_trip_output
);
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    // =====================================
    // helper counters
    logic [7:0] trip_run_q; // samples with trip high
    logic [7:0] rx_run_q;   // samples with receive high
    logic [7:0] gap_q;      // samples since the last echo start
    logic       tx_q;       // transmit one sample ago
    logic       fwd_q;      // any forward input one sample ago
    logic       echo_go;    // transmit rose with no local cause
    assign echo_go = permissive_transmit & ~tx_q & ~fwd_q;
    // counters saturate so a long run never wraps to a false short one
    always_ff @(posedge clk) begin
        if (reset) begin
            trip_run_q <= 8'h00;
            rx_run_q   <= 8'h00;
            gap_q      <= 8'hff;
        end else begin
            trip_run_q <= scheme_trip_output ?
                trip_run_q + {7'h0, ~&trip_run_q} : 8'h00;
            rx_run_q   <= field_in.permissive_receive ?
                rx_run_q + {7'h0, ~&rx_run_q} : 8'h00;
            gap_q      <= echo_go ? 8'h01 : gap_q + {7'h0, ~&gap_q};
        end
        tx_q  <= permissive_transmit;
        fwd_q <= field_in.zone2_pickup | field_in.ground_forward_indication;
    end
    // =====================================
    // properties
    a_zone_keys: assert property (
        field_in.zone2_pickup |=> permissive_transmit)
        else $error("no transmit after zone pickup");
    a_ground_keys: assert property (
        field_in.ground_forward_indication |=> permissive_transmit)
        else $error("no transmit after ground forward");
    a_echo_length: assert property (
        echo_go |-> permissive_transmit[*6] ##1 !permissive_transmit)
        else $error("echo pulse length wrong");
    a_echo_holdoff: assert property (
        echo_go |-> int'(gap_q) > ECHO_HO_CYC)
        else $error("echo repeated inside holdoff");
    a_rx_held: assert property (
        $rose(scheme_trip_output) |-> int'($past(rx_run_q)) >= RX_QUAL_CYC)
        else $error("trip on unqualified receive");
    a_trip_cause: assert property (
        $rose(scheme_trip_output) |->
        $past(field_in.zone2_pickup | field_in.ground_forward_indication))
        else $error("trip without forward indication");
    a_zone_trip: assert property (
        (field_in.permissive_receive && field_in.zone2_pickup)[*8]
        |=> scheme_trip_output)
        else $error("zone path failed to trip");
    a_trip_hold: assert property (
        $fell(scheme_trip_output) && !$past(reset) |->
        int'(trip_run_q) >= TRIP_HOLD_CYC)
        else $error("trip released before hold time");
    a_apb_wait: assert property (
        apb_req.psel && apb_req.penable && !$past(apb_req.penable)
        |-> !pready ##1 pready)
        else $error("bus answer not after one wait state");
    a_bad_addr: assert property (
        pready && !apb_req.pwrite && apb_req.paddr > 12'h020
        |-> pslverr && prdata == 32'h0)
        else $error("unmapped read not refused");
endmodule

/* pott_remote.sv */
// far-end relay model: keys the channel on its own fault or a return
`timescale 1ns/10ps
module pott_remote (
    input  wire logic       clk,
    input  wire logic       rcv,
    input  wire logic       fwd,
    input  wire logic       echo_on,
    input  wire logic [2:0] lag,
    output logic            send
);
    // channel delay line, one to eight samples long
    logic [7:0] line_q = 8'h00;
    // far end treats our transmit as its receive
    always_ff @(posedge clk) begin
        line_q <= {line_q[6:0], fwd | (echo_on & rcv)};
    end
    // lag chooses a prompt or a slow channel
    assign send = line_q[lag];
endmodule

/* test_pott_scheme.sv */
// self-checking bench for the permissive trip scheme
`timescale 1ns/10ps
module test_pott_scheme;
    // shortened timer settings, in clock cycles
    localparam int RXQ = 4, WIN = 8, BLK = 12, EPL = 6, EHO = 20;
    localparam int OPQ = 5, HLD = 10;
    logic                clk = 1'b0, reset = 1'b1;
    logic                z2 = 1'b0, gnd = 1'b0, leo = 1'b0;
    logic                fwd = 1'b0, echo_on = 1'b0;
    logic [2:0]          lag = 3'h0;
    logic                rx, tx, trip, pready, pslverr;
    logic [31:0]         prdata, rnd = 32'hf55c41f3;
    pott_pkg::apb_req_t  req = '0;
    pott_pkg::field_in_t fin;
    logic [33:0]         exp_q[$]; // {read, error, data}
    logic [33:0]         note;
    int                  num_errors = 0, n_tests = 0;
    logic [31:0]         dflt [9] = '{32'h0, 32'(RXQ), 32'(WIN),
        32'(BLK), 32'(EPL), 32'(EHO), 32'(OPQ), 32'(HLD), 32'h0};
    assign fin = {z2, gnd, rx, leo};
    pott_scheme #(.RX_QUAL_CYC(RXQ), .REV_WIN_CYC(WIN), .REV_BLK_CYC(BLK),
        .ECHO_PL_CYC(EPL), .ECHO_HO_CYC(EHO), .OPEN_QUAL_CYC(OPQ),
        .TRIP_HOLD_CYC(HLD)) pott_scheme_i (.clk(clk), .reset(reset),
        .field_in(fin), .apb_req(req), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .permissive_transmit(tx),
        .scheme_trip_output(trip));
    pott_remote pott_remote_i (.clk(clk), .rcv(tx), .fwd(fwd),
        .echo_on(echo_on), .lag(lag), .send(rx));
    initial forever #50 clk = ~clk;
    // =====================================
    // helpers
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic go(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] want);
        n_tests++;
        if (got !== want) begin
            num_errors++;
            $display("ERROR %0t got %h want %h", $time, got, want);
        end
    endtask
    // one bus transfer; the expected answer is queued first
    task automatic apb(input logic wr, input logic [11:0] a,
                       input logic [31:0] d, input logic [32:0] want);
        exp_q.push_back({~wr, want});
        @(posedge clk);
        req <= '{1'b1, 1'b0, wr, a, d};
        @(posedge clk);
        req.penable <= 1'b1;
        // no cycle count assumed: only the watchdog ends a hung wait
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        req <= '0;
    endtask
    task automatic print_verdict();
        $display("checks %0d errors %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    // scoreboard: each bus answer is matched to the oldest note
    always @(posedge clk) begin
        if (!reset && pready === 1'b1 && exp_q.size() > 0) begin
            note = exp_q.pop_front();
            chk({31'h0, pslverr}, {31'h0, note[32]});
            if (note[33])
                chk(prdata, note[31:0]);
        end
    end
    // watchdog, far beyond the few hundred cycles the tests need
    initial begin
        go(3000);
        num_errors++;
        print_verdict();
    end
    // =====================================
    // scenarios
    initial begin
        go(16);
        reset <= 1'b0;
        for (int i = 0; i < 9; i++)
            apb(1'b0, 12'(4 * i), 32'h0, {1'b0, dflt[i]});
        apb(1'b1, 12'h000, 32'h1, 33'h0);
        rnd = lfsr(rnd);
        apb(1'b1, 12'h004, rnd, 33'h0);
        apb(1'b0, 12'h004, 32'h0, {9'h0, rnd[23:0]});
        apb(1'b1, 12'h004, 32'(RXQ), 33'h0);
        apb(1'b0, 12'h000, 32'h0, 33'h1);
        apb(1'b1, 12'h020, 32'h3, {1'b1, 32'h0});
        apb(1'b0, 12'h024, 32'h0, {1'b1, 32'h0});
        $display("test registers done");
        // zone key, remote return over a random lag, sealed trip
        rnd = lfsr(rnd);
        lag <= {1'b0, rnd[1:0]};
        echo_on <= 1'b1;
        z2 <= 1'b1;
        go(2);
        chk(tx, 1'b1);
        go(40);
        chk(trip, 1'b1);
        apb(1'b0, 12'h020, 32'h0, 33'h7);
        z2 <= 1'b0;
        go(6);
        chk(trip, 1'b1);
        go(20);
        chk({trip, tx}, 2'b00);
        echo_on <= 1'b0;
        lag <= 3'h0;
        $display("test zone trip done");
        // receive burst shorter than the qualify delay
        z2 <= 1'b1;
        fwd <= 1'b1;
        go(3);
        fwd <= 1'b0;
        go(15);
        chk(trip, 1'b0);
        z2 <= 1'b0;
        go(4);
        $display("test short receive done");
        // ground path: pass in window, then cut and blocked
        {gnd, fwd} <= 2'b11;
        go(11);
        chk(trip, 1'b1);
        apb(1'b0, 12'h020, 32'h0, 33'h27);
        fwd <= 1'b0;
        go(1);
        fwd <= 1'b1;
        go(14);
        chk(trip, 1'b0);
        {gnd, fwd} <= 2'b00;
        go(30);
        $display("test ground path done");
        // no echo while open end is not yet valid
        leo <= 1'b1;
        go(3);
        leo <= 1'b0;
        fwd <= 1'b1;
        go(11);
        chk(tx, 1'b0);
        fwd <= 1'b0;
        leo <= 1'b1;
        go(10);
        fwd <= 1'b1;
        go(11);
        chk(tx, 1'b1);
        go(8);
        chk(tx, 1'b0);
        fwd <= 1'b0;
        go(1);
        fwd <= 1'b1;
        go(10);
        chk(tx, 1'b0);
        fwd <= 1'b0;
        go(40);
        fwd <= 1'b1;
        go(5);
        apb(1'b0, 12'h020, 32'h0, 33'h1d);
        go(2);
        chk(tx, 1'b1);
        fwd <= 1'b0;
        go(10);
        $display("test echo done");
        print_verdict();
    end
endmodule
bind pott_scheme pott_scheme_asserts #(.RX_QUAL_CYC(RX_QUAL_CYC),
    .ECHO_HO_CYC(ECHO_HO_CYC), .TRIP_HOLD_CYC(TRIP_HOLD_CYC))
    asserts_i (.clk(clk), .reset(reset), .field_in(field_in),
    .apb_req(apb_req), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .permissive_transmit(permissive_transmit),
    .scheme_trip_output(scheme_trip_output));
